// [hw/sad_decoder.v]
// System address decoder: flash, SRAM aliases, peripheral bridges
`timescale 1ns/100ps
`include "sad_defs.vh"
module sad_decoder #(
    parameter FLASH0_SIZE = `SAD_FLASH0_SIZE,
    parameter FLASH1_SIZE = `SAD_FLASH1_SIZE,
    parameter SRAM_SIZE   = `SAD_SRAM_SIZE,
    parameter BRIDGE_SIZE = `SAD_BRIDGE_SIZE
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_b,
    // Configuration
    input  wire        flashSwap,
    // Master request
    input  wire        reqValid,
    input  wire        reqWrite,
    input  wire        reqFromCpu,
    input  wire [31:0] reqAddr,
    // Target handshake
    input  wire        tgtDone,
    // Decoded access
    output reg         accValid,
    output reg         accWrite,
    output reg  [2:0]  accTarget,
    output reg  [31:0] accOffset,
    output reg         accBuffered,
    output reg         accError,
    // Master completion
    output reg         reqDone,
    output reg         busy
);
    // ------------------------------------------------------------
    // Window matching
    // ------------------------------------------------------------
    // Flash bank placement
    wire [31:0] flashHiBase;
    wire [31:0] flashLoSize;
    wire [31:0] flashHiSize;
    // Window hits
    wire        hitLo;
    wire        hitHi;
    wire        hitTcm;
    wire        hitSb;
    wire        hitSn;
    wire        hitPb;
    wire        hitPn;
    // Offsets inside each window
    wire [31:0] offLo;
    wire [31:0] offHi;
    wire [31:0] offTcm;
    wire [31:0] offSb;
    wire [31:0] offSn;
    wire [31:0] offPb;
    wire [31:0] offPn;

    // Bank at boot decides where the other begins
    assign flashLoSize = flashSwap ? FLASH1_SIZE : FLASH0_SIZE;
    assign flashHiSize = flashSwap ? FLASH0_SIZE : FLASH1_SIZE;
    assign flashHiBase = `SAD_BOOT_BASE + flashLoSize;

    // Both bridges of one peripheral window, side by side
    localparam [31:0] PERI_SIZE = BRIDGE_SIZE * 2;

    // Bank at the boot address
    sad_window_match #(
        .AW     (32)
    ) uLo (
        .addr   (reqAddr),
        .base   (`SAD_BOOT_BASE),
        .size   (flashLoSize),
        .hit    (hitLo),
        .offset (offLo)
    );

    // Other bank, right after the boot bank
    sad_window_match #(
        .AW     (32)
    ) uHi (
        .addr   (reqAddr),
        .base   (flashHiBase),
        .size   (flashHiSize),
        .hit    (hitHi),
        .offset (offHi)
    );

    // SRAM through the tightly coupled data port
    sad_window_match #(
        .AW     (32)
    ) uTcm (
        .addr   (reqAddr),
        .base   (`SAD_TCM_BASE),
        .size   (SRAM_SIZE),
        .hit    (hitTcm),
        .offset (offTcm)
    );

    // SRAM alias for buffered system-bus access
    sad_window_match #(
        .AW     (32)
    ) uSb (
        .addr   (reqAddr),
        .base   (`SAD_SRAM_BUF_BASE),
        .size   (SRAM_SIZE),
        .hit    (hitSb),
        .offset (offSb)
    );

    // SRAM alias for non-buffered system-bus access
    sad_window_match #(
        .AW     (32)
    ) uSn (
        .addr   (reqAddr),
        .base   (`SAD_SRAM_NBUF_BASE),
        .size   (SRAM_SIZE),
        .hit    (hitSn),
        .offset (offSn)
    );

    // Buffered peripheral window, both bridges
    sad_window_match #(
        .AW     (32)
    ) uPb (
        .addr   (reqAddr),
        .base   (`SAD_PERI_BUF_BASE),
        .size   (PERI_SIZE),
        .hit    (hitPb),
        .offset (offPb)
    );

    // Non-buffered peripheral window, same bridges
    sad_window_match #(
        .AW     (32)
    ) uPn (
        .addr   (reqAddr),
        .base   (`SAD_PERI_NBUF_BASE),
        .size   (PERI_SIZE),
        .hit    (hitPn),
        .offset (offPn)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    reg [2:0]  next_target;
    reg [31:0] next_offset;
    reg        next_buffered;

    // Priority chain; windows never overlap, so order is cosmetic
    always @* begin
        next_target   = `SAD_TGT_NONE;
        next_offset   = 32'h0000_0000;
        next_buffered = 1'b0;
        if (hitLo) begin
            next_target = flashSwap ? `SAD_TGT_FLASH1
                                    : `SAD_TGT_FLASH0;
            next_offset = offLo;
        end else if (hitHi) begin
            next_target = flashSwap ? `SAD_TGT_FLASH0
                                    : `SAD_TGT_FLASH1;
            next_offset = offHi;
        end else if (hitTcm) begin
            next_target = `SAD_TGT_TCM;
            next_offset = offTcm;
        end else if (hitSb) begin
            next_target   = `SAD_TGT_SRAM;
            next_offset   = offSb;
            next_buffered = reqFromCpu;
        end else if (hitSn) begin
            next_target = `SAD_TGT_SRAM;
            next_offset = offSn;
        end else if (hitPb) begin
            // Bridge picked by bit 26, offset below it
            next_target   = offPb[`SAD_BRIDGE_BIT] ? `SAD_TGT_BRIDGE1
                                                   : `SAD_TGT_BRIDGE0;
            next_offset   = {6'h00, offPb[25:0]};
            next_buffered = reqFromCpu;
        end else if (hitPn) begin
            next_target = offPn[`SAD_BRIDGE_BIT] ? `SAD_TGT_BRIDGE1
                                                 : `SAD_TGT_BRIDGE0;
            next_offset = {6'h00, offPn[25:0]};
        end
    end

    // ------------------------------------------------------------
    // Access sequencing
    // ------------------------------------------------------------
    // Early ack only for buffered writes; reads always need data
    wire earlyAck = next_buffered && reqWrite;
    wire noTarget = (next_target == `SAD_TGT_NONE);

    // One access in flight; new requests wait while busy
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            accValid    <= 1'b0;
            accWrite    <= 1'b0;
            accTarget   <= 3'h0;
            accOffset   <= 32'h0000_0000;
            accBuffered <= 1'b0;
            accError    <= 1'b0;
            reqDone     <= 1'b0;
            busy        <= 1'b0;
        end else begin
            accValid <= 1'b0;
            reqDone  <= 1'b0;
            accError <= 1'b0;
            if (!busy && reqValid) begin
                accWrite    <= reqWrite;
                accTarget   <= next_target;
                accOffset   <= next_offset;
                accBuffered <= next_buffered;
                if (noTarget) begin
                    // Unmapped: complete at once with error
                    reqDone  <= 1'b1;
                    accError <= 1'b1;
                end else begin
                    accValid <= 1'b1;
                    busy     <= 1'b1;
                    reqDone  <= earlyAck;
                end
            end else if (busy && tgtDone) begin
                busy    <= 1'b0;
                reqDone <= !(accBuffered && accWrite);
            end
        end
    end
endmodule // sad_decoder

// [hw/sad_defs.vh]
// Address map constants for the system address decoder
// How it works
// - Primary flash sits at boot address by default.
// - Swap option puts secondary flash at boot.
// - SRAM aliased in three windows.
// - Non-CPU masters always get non-buffered SRAM access.
// - CPU first peripheral range gives buffered bridge access.
// - CPU second peripheral range gives non-buffered bridge access.
// - Peripheral selected by bridge base plus offset.
`ifndef SAD_DEFS_VH
`define SAD_DEFS_VH

// ----------------------------------------------------------------
// Address windows
// ----------------------------------------------------------------
`define SAD_BOOT_BASE      32'h0000_0000
`define SAD_TCM_BASE       32'h0400_0000
`define SAD_SRAM_BUF_BASE  32'h4000_0000
`define SAD_SRAM_NBUF_BASE 32'h5000_0000
`define SAD_PERI_BUF_BASE  32'h4800_0000
`define SAD_PERI_BUF_LAST  32'h4FFF_FFFF
`define SAD_PERI_NBUF_BASE 32'h5800_0000
`define SAD_PERI_NBUF_LAST 32'h5FFF_FFFF
// Top 5 address bits pick a 128 MB window
`define SAD_WIN_MSB        31
`define SAD_WIN_LSB        27
// Bridge split inside a peripheral window: bit 26
`define SAD_BRIDGE_BIT     26

// ----------------------------------------------------------------
// Default window sizes
// ----------------------------------------------------------------
`define SAD_FLASH0_SIZE    32'h0008_0000
`define SAD_FLASH1_SIZE    32'h0000_8000
`define SAD_SRAM_SIZE      32'h0001_8000
`define SAD_BRIDGE_SIZE    32'h0400_0000

// ----------------------------------------------------------------
// Target codes
// ----------------------------------------------------------------
`define SAD_TGT_NONE       3'h0
`define SAD_TGT_FLASH0     3'h1
`define SAD_TGT_FLASH1     3'h2
`define SAD_TGT_TCM        3'h3
`define SAD_TGT_SRAM       3'h4
`define SAD_TGT_BRIDGE0    3'h5
`define SAD_TGT_BRIDGE1    3'h6

`endif

// [hw/sad_window_match.v]
// Window compare: base and size to hit flag and offset
`timescale 1ns/100ps
module sad_window_match #(
    parameter AW = 32
) (
    // Address and window
    input  wire [AW-1:0] addr,
    input  wire [AW-1:0] base,
    input  wire [AW-1:0] size,
    // Result
    output wire          hit,
    output wire [AW-1:0] offset
);
    // Offset is only meaningful while hit is high
    assign offset = addr - base;
    assign hit    = (addr >= base) && (offset < size);
endmodule // sad_window_match

// [sim/sad_decoder_sva.sv]
// Concurrent checks on the system address decoder ports
`timescale 1ns/100ps
module sad_decoder_sva (
    // Clock and reset
    input wire        ref_clk,
    input wire        rst_b,
    // Configuration and request
    input wire        flashSwap,
    input wire        reqValid,
    input wire        reqWrite,
    input wire        reqFromCpu,
    input wire [31:0] reqAddr,
    // Target handshake
    input wire        tgtDone,
    // Decoded access
    input wire        accValid,
    input wire        accWrite,
    input wire [2:0]  accTarget,
    input wire [31:0] accOffset,
    input wire        accBuffered,
    input wire        accError,
    // Master completion
    input wire        reqDone,
    input wire        busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Request taken this edge and its 128 MB window
    wire       tk = reqValid && !busy;
    wire [4:0] win = reqAddr[31:27];
    chk_boot_map: assert property (tk && !flashSwap &&
        reqAddr < 32'h0008_0000 |=> accTarget == 3'h1) else $error("boot");
    chk_swap_map: assert property (tk && flashSwap &&
        reqAddr < 32'h0000_8000 |=> accTarget == 3'h2) else $error("swap");
    chk_sram_win: assert property (tk && win[4:2] == 3'h2 &&
        reqAddr[27:0] < 28'h001_8000 |=> accTarget == 3'h4)
        else $error("sram");
    chk_dma_nobuf: assert property (tk && !reqFromCpu
        |=> !accBuffered) else $error("dma buffered");
    chk_peri_buf: assert property (tk && reqFromCpu &&
        win == 5'h09 |=> accBuffered) else $error("bridge buffered");
    chk_peri_nbuf: assert property (tk && win == 5'h0B
        |=> !accBuffered) else $error("bridge unbuffered");
    chk_bridge_sel: assert property (tk && win[4:2] == 3'h2 &&
        win[0] |=> accTarget == ($past(reqAddr[26]) ? 3'h6 : 3'h5) &&
        accOffset == {6'h00, $past(reqAddr[25:0])}) else $error("bridge");
    chk_tgt_wait: assert property (busy && tgtDone &&
        !(accBuffered && accWrite) |=> reqDone && !busy) else $error("done");
    chk_early_ack: assert property (tk && reqFromCpu && reqWrite &&
        win == 5'h09 |=> reqDone && busy) else $error("early ack");
    chk_err_done: assert property (accError |-> reqDone &&
        !accValid && !busy) else $error("error done");
endmodule // sad_decoder_sva
bind sad_decoder sad_decoder_sva u_chk (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .flashSwap   (flashSwap),
    .reqValid    (reqValid),
    .reqWrite    (reqWrite),
    .reqFromCpu  (reqFromCpu),
    .reqAddr     (reqAddr),
    .tgtDone     (tgtDone),
    .accValid    (accValid),
    .accWrite    (accWrite),
    .accTarget   (accTarget),
    .accOffset   (accOffset),
    .accBuffered (accBuffered),
    .accError    (accError),
    .reqDone     (reqDone),
    .busy        (busy)
);

// [sim/sad_target_model.sv]
// Far-side target: answers each issued access after a set wait
`timescale 1ns/100ps
module sad_target_model (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // Access from the decoder and wait length
    input  wire       accValid,
    input  wire [3:0] dly,
    // Completion pulse back to the decoder
    output wire       tgtDone
);
    reg [4:0] cnt;
    // Slow answer exposes any completion that skips the target
    assign tgtDone = cnt == 5'h01;
    // Load on issue, count down to one, then idle at zero
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) cnt <= 5'h00;
        else cnt <= accValid ? {1'b0, dly} + 5'h01 : cnt - {4'h0, |cnt};
    end
endmodule // sad_target_model

// [sim/test_system_address_decoder.sv]
// Self-checking bench for the system address decoder
`timescale 1ns/100ps
module test_system_address_decoder;
    logic        ref_clk = 0, rst_b = 0, flashSwap = 0, reqValid = 0;
    logic        reqWrite = 0, reqFromCpu = 0, tgtDone, accValid, accWrite;
    logic        accBuffered, accError, reqDone, busy;
    logic [31:0] reqAddr = 0, accOffset;
    logic [3:0]  dly = 1;
    logic [2:0]  accTarget;
    int          errTotal = 0, nCompared = 0;
    sad_decoder dut (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .flashSwap   (flashSwap),
        .reqValid    (reqValid),
        .reqWrite    (reqWrite),
        .reqFromCpu  (reqFromCpu),
        .reqAddr     (reqAddr),
        .tgtDone     (tgtDone),
        .accValid    (accValid),
        .accWrite    (accWrite),
        .accTarget   (accTarget),
        .accOffset   (accOffset),
        .accBuffered (accBuffered),
        .accError    (accError),
        .reqDone     (reqDone),
        .busy        (busy)
    );
    sad_target_model u_tgt (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .accValid (accValid),
        .dly      (dly),
        .tgtDone  (tgtDone)
    );
    initial forever #20 ref_clk = ~ref_clk;
    task automatic chk(string n, logic [39:0] s, logic [39:0] e);
        nCompared++;
        if (s !== e) errTotal++;
        if (s !== e) $display("[ERR] %s exp %h seen %h", n, e, s);
    endtask
    task automatic completeRun;
        $display("compares %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // One access; only a buffered write may finish before the target
    task automatic acc(logic [31:0] a, logic w, c, logic [2:0] t,
                       logic [31:0] off, logic b);
        @(posedge ref_clk);
        {reqValid, reqWrite, reqFromCpu, reqAddr} <= {1'b1, w, c, a};
        @(posedge ref_clk) reqValid <= 1'b0;
        #1 chk("acc", {accValid, accWrite, accError, accBuffered,
            reqDone, accTarget, accOffset},
            {1'b1, w, 1'b0, b, w & b, t, off});
        for (int i = 0; i < 40 && busy; i++) @(posedge ref_clk) #1;
        chk("done", {busy, reqDone}, {1'b0, !(w & b)});
    endtask
    task automatic flashOrder;
        acc(32'h0000_0040, 0, 1, 3'h1, 32'h0000_0040, 0);
        @(posedge ref_clk) flashSwap <= 1;
        acc(32'h0000_0040, 0, 1, 3'h2, 32'h0000_0040, 0);
        acc(32'h0000_8000, 0, 1, 3'h1, 32'h0000_0000, 0);
    endtask
    // SRAM aliases and bridges; slow target for the bridges
    task automatic aliasRoutes;
        acc(32'h0400_0010, 1, 0, 3'h3, 32'h0000_0010, 0);
        acc(32'h4001_7FFC, 1, 1, 3'h4, 32'h0001_7FFC, 1);
        @(posedge ref_clk) dly <= 7;
        acc(32'h4800_0004, 1, 1, 3'h5, 32'h0000_0004, 1);
        acc(32'h4FFF_FFFC, 0, 1, 3'h6, 32'h03FF_FFFC, 1);
        acc(32'h5800_0008, 1, 1, 3'h5, 32'h0000_0008, 0);
    endtask
    // Other masters never buffered; unmapped ends at once with error
    task automatic dmaAndHoles;
        acc(32'h4000_0020, 1, 0, 3'h4, 32'h0000_0020, 0);
        acc(32'h4800_0100, 1, 0, 3'h5, 32'h0000_0100, 0);
        acc(32'h5000_0010, 0, 1, 3'h4, 32'h0000_0010, 0);
        @(posedge ref_clk);
        {reqValid, reqWrite, reqFromCpu, reqAddr} <= {3'b101, 32'h4001_8000};
        @(posedge ref_clk) reqValid <= 1'b0;
        #1 chk("hole", {accValid, accError, reqDone, busy}, 4'h6);
    endtask
    // Reset during an access leaves the block idle and reusable
    task automatic midReset;
        @(posedge ref_clk);
        {reqValid, reqWrite, reqFromCpu, reqAddr} <= {3'b101, 32'h5C00_0010};
        @(posedge ref_clk) reqValid <= 1'b0;
        @(posedge ref_clk) rst_b <= 1'b0;
        @(posedge ref_clk) #1;
        chk("reset", {busy, accValid, reqDone, accError}, 4'h0);
        @(posedge ref_clk) rst_b <= 1'b1;
        acc(32'h5C00_0010, 0, 1, 3'h6, 32'h0000_0010, 0);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1;
        flashOrder();
        aliasRoutes();
        dmaAndHoles();
        midReset();
        completeRun();
    end
    // Run takes under 150 cycles; 5000 means a hang
    initial #200000 begin
        errTotal++;
        completeRun();
    end
endmodule // test_system_address_decoder
